// ---- design/clk_pkg.sv ----
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - Push locks aligned segment, then decrements pointer
// - Push disabled: no lock, pointer kept
// - Pop increments pointer, then releases that slot
// - Pop strobe always reads back zero
// - Pointer read-only; slots above it locked
// - Pointer zero means whole cache unlocked
// - Accumulator counts every miss stall cycle except one with an accumulator write
// - Overflow flag sticky until accumulator written
// - High field shows accumulator bits 11-5
// - High field write clears low five bits
// - High field read snapshots bits 4-1
// - Bit 0 hidden; total is twice fields
// - Tuning bits 7-4 hold captured snapshot
// - Pop releases lock only, contents stay
// - Push locks even with fill writes disabled
package clk_pkg;
	//------------------------------------------------------------------
	// Register byte addresses
	//------------------------------------------------------------------
	localparam logic [3:0] CLK_OFS_LOCK = 4'h0; // Lock control
	localparam logic [3:0] CLK_OFS_ACCUM = 4'h4; // Miss accumulator high
	localparam logic [3:0] CLK_OFS_TUNE = 4'h8; // Tuning, low field on top
	localparam logic [3:0] CLK_OFS_CTRL = 4'hc; // Fill write enable
	//------------------------------------------------------------------
	// Field positions
	//------------------------------------------------------------------
	localparam int CLK_BIT_PUSH = 7; // Push enable
	localparam int CLK_BIT_POP = 6; // Pop strobe
	localparam int CLK_BIT_OVF = 7; // Overflow flag
	localparam int CLK_BIT_WREN = 0; // Fill write enable
	localparam int CLK_SLOT_W = 6; // Slot pointer width
	localparam int CLK_ACC_W = 12; // Accumulator width
	localparam int CLK_HIGH_W = 7; // High field width
	localparam int CLK_HIGH_LSB = 5; // Accumulator bit at high field bit 0
	localparam int CLK_LOW_W = 4; // Low field width
	localparam int CLK_TUNE_W = 4; // Plain tuning bits 3-0
	localparam int CLK_SEG_LSB = 2; // Four-byte segment alignment
	//------------------------------------------------------------------
	// Reset values
	//------------------------------------------------------------------
	localparam logic [CLK_SLOT_W-1:0] CLK_SLOT_RST = 6'h3e; // Empty stack
	localparam logic CLK_PUSH_RST = 1'b0;
	localparam logic [CLK_TUNE_W-1:0] CLK_TUNE_RST = 4'h4;
	localparam logic CLK_WREN_RST = 1'b1;
	localparam logic [CLK_SLOT_W-1:0] CLK_SLOT_ZERO = 6'h00;
	localparam logic [CLK_SLOT_W-1:0] CLK_SLOT_ONE = 6'h01;
	localparam logic [CLK_ACC_W-1:0] CLK_ACC_ONE = 12'h001;
	localparam logic [CLK_ACC_W-1:0] CLK_ACC_MAX = 12'hfff;
	localparam logic [CLK_HIGH_LSB-1:0] CLK_ACC_LOW_CLR = 5'h00;
	localparam logic [31:0] CLK_RD_ZERO = 32'h0000_0000;
endpackage : clk_pkg

// ---- design/clk_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module clk_top
	import clk_pkg::*;
#(
	parameter int ADDR_W = 16 // Program address width
)
(
	input wire logic clk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core fetch and program-read side
	input wire logic prog_read_op,
	input wire logic [ADDR_W-1:0] prog_read_addr,
	input wire logic miss_stall,
	input wire logic fill_request,
	input wire logic [CLK_SLOT_W-1:0] fill_slot,
	// Cache array side
	output logic lock_write,
	output logic [CLK_SLOT_W-1:0] lock_write_slot,
	output logic [ADDR_W-CLK_SEG_LSB-1:0] lock_write_segment,
	output logic lock_release,
	output logic [CLK_SLOT_W-1:0] lock_release_slot,
	output logic fill_grant,
	output logic [CLK_SLOT_W-1:0] lock_slot_pointer,
	output logic cache_fill_write_enable
);
	//------------------------------------------------------------------
	// Elaboration checks
	//------------------------------------------------------------------
	if (ADDR_W <= CLK_SEG_LSB)
	begin : g_bad_addr_w
		$error("ADDR_W too small for segment addressing");
	end

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	// Slot protected from normal fills; zero pointer unlocks everything
	function automatic logic slot_locked(input logic [CLK_SLOT_W-1:0] slot,
		input logic [CLK_SLOT_W-1:0] ptr);
		slot_locked = (ptr != CLK_SLOT_ZERO) && (slot > ptr);
	endfunction : slot_locked

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	logic wait_q; // Waitrequest, high when idle
	logic [31:0] rdata_q; // Read data
	logic push_en_q; // Push enable
	logic [CLK_SLOT_W-1:0] slot_q; // Slot pointer
	logic [CLK_ACC_W-1:0] acc_q; // Miss penalty accumulator
	logic ovf_q; // Overflow flag
	logic [CLK_LOW_W-1:0] low_q; // Snapshot of accumulator bits 4-1
	logic [CLK_TUNE_W-1:0] tune_q; // Plain tuning bits
	logic wren_q; // Fill write enable
	logic lock_write_q;
	logic [CLK_SLOT_W-1:0] lock_write_slot_q;
	logic [ADDR_W-CLK_SEG_LSB-1:0] lock_write_seg_q;
	logic lock_release_q;
	logic [CLK_SLOT_W-1:0] lock_release_slot_q;
	logic fill_grant_q;

	//------------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------------
	logic acc_wr; // Write taken this edge
	logic acc_rd; // Read taken this edge
	logic lane0; // Low byte enabled
	logic wr_lock; // Lock control written
	logic wr_accum; // Accumulator written
	logic rd_accum; // Accumulator read taken
	logic push_go; // Push happens this edge
	logic pop_go; // Pop happens this edge

	// Transfers complete at the edge where waitrequest is low
	assign acc_wr = avs_write && !wait_q;
	assign acc_rd = avs_read && !wait_q;
	assign lane0 = avs_byteenable[0];
	assign wr_lock = acc_wr && lane0 && (avs_address == CLK_OFS_LOCK);
	assign wr_accum = acc_wr && lane0 && (avs_address == CLK_OFS_ACCUM);
	assign rd_accum = acc_rd && (avs_address == CLK_OFS_ACCUM);
	assign push_go = prog_read_op && push_en_q;
	assign pop_go = wr_lock && avs_writedata[CLK_BIT_POP];

	//------------------------------------------------------------------
	// Bus handshake
	//------------------------------------------------------------------
	// One wait cycle per access so read data comes from a flop
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wait_q <= 1'b1;
		else
			wait_q <= !((avs_read || avs_write) && wait_q);
	end

	// Read mux, captured in the wait cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= CLK_RD_ZERO;
		else if (avs_read && wait_q)
		begin
			rdata_q <= CLK_RD_ZERO;
			case (avs_address)
				CLK_OFS_LOCK:
				begin
					rdata_q[CLK_BIT_PUSH] <= push_en_q;
					rdata_q[CLK_SLOT_W-1:0] <= slot_q;
				end
				CLK_OFS_ACCUM:
				begin
					rdata_q[CLK_BIT_OVF] <= ovf_q;
					// Bit 0 never reaches the bus
					rdata_q[CLK_HIGH_W-1:0] <= acc_q[CLK_ACC_W-1:CLK_HIGH_LSB];
				end
				CLK_OFS_TUNE:
				begin
					// Snapshot on top of tuning bits
					rdata_q[CLK_TUNE_W+CLK_LOW_W-1:CLK_TUNE_W] <= low_q;
					rdata_q[CLK_TUNE_W-1:0] <= tune_q;
				end
				CLK_OFS_CTRL:
					rdata_q[CLK_BIT_WREN] <= wren_q;
				default:
					// Unmapped reads return zero
					rdata_q <= CLK_RD_ZERO;
			endcase
		end
	end

	//------------------------------------------------------------------
	// Lock stack
	//------------------------------------------------------------------
	// Push enable follows software
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			push_en_q <= CLK_PUSH_RST;
		else if (wr_lock)
			push_en_q <= avs_writedata[CLK_BIT_PUSH];
	end

	// Pointer moves only by push and pop; software cannot load it
	// Read-only pointer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			slot_q <= CLK_SLOT_RST;
		else if (push_go && !pop_go)
			slot_q <= slot_q - CLK_SLOT_ONE;
		else if (pop_go && !push_go)
			slot_q <= slot_q + CLK_SLOT_ONE;
	end

	// Lock write ignores fill write enable on purpose
	// Push despite fill disable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lock_write_q <= 1'b0;
			lock_write_slot_q <= CLK_SLOT_ZERO;
			lock_write_seg_q <= '0;
		end
		else
		begin
			lock_write_q <= push_go;
			if (push_go)
			begin
				lock_write_slot_q <= slot_q;
				lock_write_seg_q <= prog_read_addr[ADDR_W-1:CLK_SEG_LSB];
			end
		end
	end

	// Release names the slot after the increment; data stay cached
	// Release lock only
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lock_release_q <= 1'b0;
			lock_release_slot_q <= CLK_SLOT_ZERO;
		end
		else
		begin
			lock_release_q <= pop_go;
			if (pop_go)
				lock_release_slot_q <= slot_q + CLK_SLOT_ONE;
		end
	end

	// Normal fill permission, one cycle after the request
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			fill_grant_q <= 1'b0;
		else
			fill_grant_q <= fill_request && wren_q && !slot_locked(fill_slot, slot_q);
	end

	//------------------------------------------------------------------
	// Miss penalty accumulator
	//------------------------------------------------------------------
	// A write in a stall cycle drops that one stall count
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acc_q <= '0;
		else if (wr_accum)
			// Clear low five bits on write
			acc_q <= {avs_writedata[CLK_HIGH_W-1:0], CLK_ACC_LOW_CLR};
		else if (miss_stall)
			acc_q <= acc_q + CLK_ACC_ONE;
	end

	// Flag set at the wrap, cleared only by a write
	// Sticky overflow flag
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ovf_q <= 1'b0;
		else if (wr_accum)
			ovf_q <= 1'b0;
		else if (miss_stall && (acc_q == CLK_ACC_MAX))
			ovf_q <= 1'b1;
	end

	// Snapshot of bits 4-1 taken with the high field read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			low_q <= '0;
		else if (rd_accum)
			low_q <= acc_q[CLK_HIGH_LSB-1:CLK_HIGH_LSB-CLK_LOW_W];
	end

	//------------------------------------------------------------------
	// Tuning and control bits
	//------------------------------------------------------------------
	// Plain storage; top nibble of tuning is the snapshot
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tune_q <= CLK_TUNE_RST;
			wren_q <= CLK_WREN_RST;
		end
		else
		begin
			if (acc_wr && lane0 && (avs_address == CLK_OFS_TUNE))
				tune_q <= avs_writedata[CLK_TUNE_W-1:0];
			if (acc_wr && lane0 && (avs_address == CLK_OFS_CTRL))
				wren_q <= avs_writedata[CLK_BIT_WREN];
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign lock_write = lock_write_q;
	assign lock_write_slot = lock_write_slot_q;
	assign lock_write_segment = lock_write_seg_q;
	assign lock_release = lock_release_q;
	assign lock_release_slot = lock_release_slot_q;
	assign fill_grant = fill_grant_q;
	assign lock_slot_pointer = slot_q;
	assign cache_fill_write_enable = wren_q;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_push;
		push_go && !pop_go;
	endsequence

	sequence s_pop;
		pop_go && !push_go;
	endsequence

	a_push_lock_dec: assert property (s_push |=> lock_write &&
		(lock_write_slot == $past(slot_q)) && (slot_q == $past(slot_q) - CLK_SLOT_ONE))
		else $error("push did not lock and decrement");

	a_push_off_hold: assert property (!push_en_q && !pop_go |=> !lock_write &&
		$stable(slot_q))
		else $error("pointer or lock moved without push");

	a_pop_inc_rel: assert property (s_pop |=> lock_release &&
		(slot_q == $past(slot_q) + CLK_SLOT_ONE) && (lock_release_slot == slot_q))
		else $error("pop did not increment and release");

	a_pop_reads_zero: assert property (rd_accum || !(acc_rd &&
		avs_address == CLK_OFS_LOCK) || !avs_readdata[CLK_BIT_POP])
		else $error("pop strobe read back nonzero");

	a_ptr_write_ro: assert property (wr_lock && !pop_go && !push_go |=>
		$stable(slot_q))
		else $error("software write changed pointer");

	a_fill_lock_gate: assert property (fill_request && wren_q &&
		(slot_q == CLK_SLOT_ZERO) |=> fill_grant)
		else $error("fill refused with zero pointer");

	a_stall_count: assert property (miss_stall && !wr_accum |=>
		acc_q == $past(acc_q) + CLK_ACC_ONE)
		else $error("stall cycle not counted");

	a_ovf_sticky: assert property (ovf_q && !wr_accum |=> ovf_q)
		else $error("overflow flag dropped without write");

	a_high_field_map: assert property (avs_read && wait_q &&
		avs_address == CLK_OFS_ACCUM |=> avs_readdata[CLK_HIGH_W-1:0] ==
		$past(acc_q[CLK_ACC_W-1:CLK_HIGH_LSB]))
		else $error("high field read mismatch");

	a_write_clears: assert property (wr_accum |=>
		(acc_q[CLK_HIGH_LSB-1:0] == CLK_ACC_LOW_CLR) && !ovf_q &&
		acc_q[CLK_ACC_W-1:CLK_HIGH_LSB] == $past(avs_writedata[CLK_HIGH_W-1:0]))
		else $error("accumulator write did not load and clear");

	a_snapshot_take: assert property (rd_accum |=>
		low_q == $past(acc_q[CLK_HIGH_LSB-1:CLK_HIGH_LSB-CLK_LOW_W]))
		else $error("snapshot not captured on high read");

	a_wrap_flag: assert property (miss_stall && !wr_accum &&
		acc_q == CLK_ACC_MAX |=> ovf_q && (acc_q == '0))
		else $error("wrap did not flag overflow");

	a_push_no_wren: assert property (push_go && !wren_q |=> lock_write)
		else $error("push blocked by fill disable");
endmodule : clk_top
`default_nettype wire

// ---- testbench/clk_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Core fetch side stand-in
// ------------------------------------------------------------------
module clk_core_model
	import clk_pkg::*;
#(
	parameter int ADDR_W = 16 // Program address width
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cmd_read,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [11:0] cmd_stall,
	input wire logic cmd_fill,
	input wire logic [CLK_SLOT_W-1:0] cmd_slot,
	output logic prog_read_op,
	output logic [ADDR_W-1:0] prog_read_addr,
	output logic miss_stall,
	output logic fill_request,
	output logic [CLK_SLOT_W-1:0] fill_slot
);
	logic [11:0] stall_q; // Stall cycles still owed

	// One program read per command; address scrambles when idle
	// so a stale address one idle cycle late never passes for a good one
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prog_read_op <= 1'b0;
			prog_read_addr <= '0;
			fill_request <= 1'b0;
			fill_slot <= '0;
		end
		else
		begin
			prog_read_op <= cmd_read;
			prog_read_addr <= cmd_read ? cmd_addr : ~prog_read_addr;
			fill_request <= cmd_fill;
			fill_slot <= cmd_fill ? cmd_slot : ~fill_slot;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			stall_q <= 12'h000;
		else if (cmd_stall != 12'h000)
			stall_q <= cmd_stall;
		else if (stall_q != 12'h000)
			stall_q <= stall_q - 12'h001;
	end
	assign miss_stall = (stall_q != 12'h000);
endmodule : clk_core_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench
	import clk_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf; // Lane enables, all on by default
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic cmd_read = 1'b0;
	logic [15:0] cmd_addr = 16'h0;
	logic [11:0] cmd_stall = 12'h0;
	logic cmd_fill = 1'b0;
	logic [5:0] cmd_slot = 6'h0;
	logic prog_read_op, miss_stall, fill_request, fill_grant;
	logic [15:0] prog_read_addr;
	logic [5:0] fill_slot, lock_write_slot, lock_release_slot, lock_slot_pointer;
	logic lock_write, lock_release, cache_fill_write_enable;
	logic [13:0] lock_write_segment;
	int n_mismatch = 0, n_compared = 0, n_lock = 0, n_rel = 0, n_grant = 0;
	logic [5:0] lk_slot, rel_slot; // Last locked and released slots
	logic [13:0] lk_seg;
	logic [31:0] rd; // Last read data

	always #5 clk = ~clk;

	clk_top clk_top_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.prog_read_op(prog_read_op), .prog_read_addr(prog_read_addr), .miss_stall(miss_stall),
		.fill_request(fill_request), .fill_slot(fill_slot), .lock_write(lock_write),
		.lock_write_slot(lock_write_slot), .lock_write_segment(lock_write_segment),
		.lock_release(lock_release), .lock_release_slot(lock_release_slot),
		.fill_grant(fill_grant), .lock_slot_pointer(lock_slot_pointer),
		.cache_fill_write_enable(cache_fill_write_enable));

	clk_core_model clk_core_model_inst (.clk(clk), .reset_n(reset_n), .cmd_read(cmd_read),
		.cmd_addr(cmd_addr), .cmd_stall(cmd_stall), .cmd_fill(cmd_fill), .cmd_slot(cmd_slot),
		.prog_read_op(prog_read_op), .prog_read_addr(prog_read_addr), .miss_stall(miss_stall),
		.fill_request(fill_request), .fill_slot(fill_slot));

	// ------------------------------------------------------------------
	// Pulse monitors: count one-cycle pulses, keep their slots
	// ------------------------------------------------------------------
	// Sampled mid-cycle so a task ending on the next edge already sees the count
	always @(negedge clk)
	begin
		if (lock_write === 1'b1)
		begin
			n_lock++;
			lk_slot = lock_write_slot;
			lk_seg = lock_write_segment;
		end
		if (lock_release === 1'b1)
		begin
			n_rel++;
			rel_slot = lock_release_slot;
		end
		if (fill_grant === 1'b1)
			n_grant++;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic test_done();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Bus cycle held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i >= 20)
		begin
			n_mismatch++;
			test_done();
		end
		@(posedge clk);
	endtask : bus

	task automatic op(input logic [15:0] a);
		cmd_read <= 1'b1;
		cmd_addr <= a;
		@(posedge clk);
		cmd_read <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : op

	task automatic fill(input logic [5:0] s);
		cmd_fill <= 1'b1;
		cmd_slot <= s;
		@(posedge clk);
		cmd_fill <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : fill

	task automatic stall(input int n);
		cmd_stall <= 12'(n);
		@(posedge clk);
		cmd_stall <= 12'h000;
		repeat (n + 4) @(posedge clk);
	endtask : stall

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		bus(0, 4'h0, 8'h00); chk(rd, 32'h3e); // empty stack
		bus(0, 4'h4, 8'h00); chk(rd, 32'h00); // clear at reset
		bus(0, 4'h8, 8'h00); chk(rd, 32'h04); // empty snapshot
		bus(0, 4'hc, 8'h00); chk(rd, 32'h01); // fills enabled
		bus(0, 4'h2, 8'h00); chk(rd, 32'h00); // unmapped reads zero
		// A write with the low lane disabled must be ignored
		avs_byteenable <= 4'he;
		bus(1, 4'hc, 8'h00); chk(cache_fill_write_enable, 32'h1); // lane off, kept
		avs_byteenable <= 4'hf;
		// Pointer bits written but must not move; push off
		bus(1, 4'h0, 8'h3f); // pointer write ignored
		op(16'h1237); chk(n_lock, 32'h0); // no lock
		chk(lock_slot_pointer, 32'h3e); // read only
		// Push with normal fills disabled
		bus(1, 4'hc, 8'h00); chk(cache_fill_write_enable, 32'h0); // fills off
		bus(1, 4'h0, 8'h80); // push enable
		op(16'h1237); chk(n_lock, 32'h1); // push despite fill off
		chk(lk_slot, 32'h3e); // old pointer
		chk(lk_seg, 32'h048d); // aligned segment
		chk(lock_slot_pointer, 32'h3d); // decrement
		bus(0, 4'h0, 8'h00); chk(rd, 32'hbd); // pointer readback
		fill(6'h10); chk(n_grant, 32'h0); // fills blocked
		bus(1, 4'hc, 8'h01); // fills on again
		fill(6'h3e); chk(n_grant, 32'h0); // slot above locked
		fill(6'h3d); chk(n_grant, 32'h1); // slot at pointer free
		// Pop only below the empty value
		bus(1, 4'h0, 8'hc0); // pointer at 3d, not empty
		chk(n_rel, 32'h1); // release pulse
		chk(rel_slot, 32'h3e); // incremented slot
		chk(lock_slot_pointer, 32'h3e); // increment
		bus(0, 4'h0, 8'h00); chk(rd, 32'hbe); // pop reads zero
		fill(6'h3e); chk(n_grant, 32'h2); // released slot refillable
		// Fill the stack up to the advised limit
		for (int k = 0; k < 61; k++)
			op(16'h0100 + 16'(k * 4)); // one lock per read
		chk(lock_slot_pointer, 32'h01); // 61 slots locked
		chk(n_lock, 32'h3e); // every read locked
		// One push past the limit, on purpose, to reach zero
		op(16'h0200); // pointer driven to zero
		chk(lock_slot_pointer, 32'h00); // pointer at zero
		fill(6'h3f); chk(n_grant, 32'h3); // all unlocked
		bus(1, 4'h0, 8'h40); chk(rel_slot, 32'h01); // pop from zero
		fill(6'h3f); chk(n_grant, 32'h3); // locked again
		// Accumulator
		stall(70); // seventy stall cycles
		bus(0, 4'h4, 8'h00); chk(rd, 32'h02); // bits 11-5
		bus(0, 4'h8, 8'h00); chk(rd, 32'h34); // snapshot
		bus(1, 4'h4, 8'h7f); // load near the top
		stall(40); // count through the wrap
		bus(0, 4'h4, 8'h00); chk(rd, 32'h80); // wrap flags
		bus(0, 4'h8, 8'h00); chk(rd, 32'h44); // counted past wrap
		bus(1, 4'h4, 8'h05); // reload
		bus(0, 4'h4, 8'h00); chk(rd, 32'h05); // load, flag cleared
		bus(0, 4'h8, 8'h00); chk(rd, 32'h04); // low bits cleared
		test_done();
	end
endmodule : testbench
`default_nettype wire
